//--- hw/cku_pkg.sv
// cku_pkg: constants, types and state record for the channel knob ui controller
// assumes one 250 MHz clock and a synchronous active-high reset
package cku_pkg;

  localparam int NCH   = 6;
  localparam int CHW   = 3;
  localparam int LVLW  = 4;
  localparam int NRING = 9;
  localparam int SETW  = 16;
  localparam int NEV   = 4;
  localparam int CNTW  = 31;

  localparam logic [LVLW-1:0] LVL_MAX = 4'h9;
  localparam logic [LVLW-1:0] LVL_DEF = 4'h6;
  localparam logic [LVLW-1:0] VOL_DEF = 4'h6;
  localparam logic [SETW-1:0] SET_DEF = 16'h0000;
  localparam logic [CHW-1:0]  SEL_DEF = 3'h0;

  // time figures and cycle counts at the core clock rate
  localparam int CLK_HZ          = 250_000_000;
  localparam int INACT_S         = 5;
  localparam int RESTORE_S       = 2;
  localparam int TAP_MS          = 300;
  localparam int FLASH_MS        = 250;
  localparam int INACT_CYC_DEF   = INACT_S * CLK_HZ;
  localparam int RESTORE_CYC_DEF = RESTORE_S * CLK_HZ;
  localparam int TAP_CYC_DEF     = TAP_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC_DEF   = FLASH_MS * (CLK_HZ / 1000);

  // register offsets
  localparam logic [7:0] OFF_STAT    = 8'h00;
  localparam logic [7:0] OFF_SET     = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h10;

  // event bit positions
  localparam int EV_SEL  = 0;
  localparam int EV_MUTE = 1;
  localparam int EV_CLIP = 2;
  localparam int EV_RST  = 3;

  // status register field positions
  localparam int ST_SEL  = 0;
  localparam int ST_MODE = 4;
  localparam int ST_MUTE = 5;

  // light colours
  localparam logic [1:0] COL_OFF   = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_WHITE = 2'h2;
  localparam logic [1:0] COL_RED   = 2'h3;

  typedef enum logic {MODE_VOL = 1'b0, MODE_GAIN = 1'b1} cku_mode_t;
  typedef enum logic {TAP_IDLE = 1'b0, TAP_WAIT = 1'b1} cku_tap_t;

  typedef struct packed {
    logic press;
    logic cw;
    logic ccw;
  } cku_knob_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cku_bus_t;

  typedef struct packed {
    logic [LVLW-1:0] vol;
    logic [LVLW-1:0] gain;
    logic            mute;
    logic [SETW-1:0] setting;
  } cku_chan_t;

  typedef struct packed {
    cku_chan_t [NCH-1:0]        ch;
    logic [CHW-1:0]             sel;
    cku_mode_t                  mode;
    cku_tap_t                   tap;
    logic [CNTW-1:0]            tap_cnt;
    logic [CNTW-1:0]            inact_cnt;
    logic [CNTW-1:0]            flash_cnt;
    logic                       flash_on;
    logic                       mute_white;
    logic                       press_q;
    logic                       rs_arm;
    logic [CNTW-1:0]            rs_cnt;
    logic [NEV-1:0]             irq_st;
    logic [NEV-1:0]             irq_en;
    logic [NCH-1:0]             sel_led;
    logic [NRING-1:0][1:0]      ring;
    logic [1:0]                 vol_ind;
    logic                       gain_ind;
    cku_chan_t                  act;
    logic                       restore;
    logic                       pair_clear;
    logic                       irq;
    logic [31:0]                rdata;
  } cku_state_t;

endpackage

//--- hw/cku_channel_knob_ui_controller.sv
// cku_channel_knob_ui_controller: channel select, push-rotate knob, lights,
// mute, factory restore and a small register port with interrupt
// assumes button, knob and clip inputs are clean and synchronous to core_clk
// assumes software strobes last one cycle and never come together
// long timings are parameters so that a bench may shorten them
// every output comes from the one state register
//
// Function
// R1 - select button picks channel for edits
// R2 - selected channel indicator green, others dark
// R3 - selecting recalls that channel's stored settings
// R4 - exactly one channel selected at once
// R5 - volume default; single tap gain, white ring
// R6 - gain mode: gain light white, volume off
// R7 - knob activity keeps gain mode alive
// R8 - five idle seconds or tap returns volume
// R9 - default gain six ring lights lit
// R10 - ninth ring light white at max gain
// R11 - clipping drives overload light red
// R12 - quick double tap mutes selected channel
// R13 - muted ring flashes green or white
// R14 - muted: volume indicator solid red
// R15 - tap on muted channel un-mutes it
// R16 - both buttons held at power-up two seconds
// R17 - restore returns eq, fx, comp defaults
// R18 - restore also erases paired device list
// R19 - single tap acts after detection interval
`timescale 1ns/1ns
module cku_channel_knob_ui_controller #(
  parameter int INACT_CYC   = cku_pkg::INACT_CYC_DEF,
  parameter int RESTORE_CYC = cku_pkg::RESTORE_CYC_DEF,
  parameter int TAP_CYC     = cku_pkg::TAP_CYC_DEF,
  parameter int FLASH_CYC   = cku_pkg::FLASH_CYC_DEF
) (
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  input  wire cku_pkg::cku_bus_t                 bus,
  output logic [31:0]                            rd_data,
  input  wire logic [cku_pkg::NCH-1:0]           chan_btn,
  input  wire cku_pkg::cku_knob_t                knob,
  input  wire logic                              clip,
  input  wire logic                              grille_light_button,
  input  wire logic                              feedback_elim_button,
  output logic [cku_pkg::NCH-1:0]                sel_led,
  output logic [cku_pkg::NRING-1:0][1:0]         ring,
  output logic [1:0]                             vol_ind,
  output logic                                   gain_ind,
  output cku_pkg::cku_chan_t                     act,
  output logic                                   restore,
  output logic                                   pair_clear,
  output logic                                   irq
);

  localparam logic [cku_pkg::CNTW-1:0] INACT_LAST   = cku_pkg::CNTW'(INACT_CYC - 1);
  localparam logic [cku_pkg::CNTW-1:0] RESTORE_LAST = cku_pkg::CNTW'(RESTORE_CYC - 1);
  localparam logic [cku_pkg::CNTW-1:0] TAP_LAST     = cku_pkg::CNTW'(TAP_CYC - 1);
  localparam logic [cku_pkg::CNTW-1:0] FLASH_LAST   = cku_pkg::CNTW'(FLASH_CYC - 1);

  cku_pkg::cku_state_t st_ff;
  cku_pkg::cku_state_t nxt_st;

  logic                          press_edge;
  logic                          activity;
  logic                          single_tap;
  logic                          double_tap;
  logic                          any_btn;
  logic [cku_pkg::CHW-1:0]       btn_idx;
  logic [cku_pkg::NEV-1:0]       ev;
  logic [cku_pkg::LVLW-1:0]      lvl;
  logic [1:0]                    col;
  logic                          wr_set;
  logic                          wr_clr;
  logic                          wr_en;
  logic                          turn_up;
  logic                          turn_dn;

  always_comb begin
    nxt_st     = st_ff;
    ev         = '0;
    any_btn    = 1'b0;
    btn_idx    = '0;
    lvl        = '0;
    col        = cku_pkg::COL_OFF;
    press_edge = knob.press & ~st_ff.press_q;
    activity   = press_edge | knob.cw | knob.ccw;
    // both step pulses at once cancel each other
    turn_up    = knob.cw & ~knob.ccw;
    turn_dn    = knob.ccw & ~knob.cw;
    // register write decode
    wr_set     = bus.wr && (bus.addr == cku_pkg::OFF_SET);
    wr_clr     = bus.wr && (bus.addr == cku_pkg::OFF_IRQ_CLR);
    wr_en      = bus.wr && (bus.addr == cku_pkg::OFF_IRQ_EN);
    nxt_st.press_q    = knob.press;
    // restore pulses last one cycle
    nxt_st.restore    = 1'b0;
    nxt_st.pair_clear = 1'b0;

    // tap classifier: a second press inside the window is a double tap
    double_tap = (st_ff.tap == cku_pkg::TAP_WAIT) && press_edge; // see R19
    single_tap = (st_ff.tap == cku_pkg::TAP_WAIT) && !press_edge
                 && (st_ff.tap_cnt == TAP_LAST); // see R19
    case (st_ff.tap)
      cku_pkg::TAP_IDLE: begin
        nxt_st.tap_cnt = '0;
        if (press_edge) begin
          nxt_st.tap = cku_pkg::TAP_WAIT;
        end
      end
      cku_pkg::TAP_WAIT: begin
        nxt_st.tap_cnt = st_ff.tap_cnt + 1'b1;
        if (double_tap || single_tap) begin
          nxt_st.tap     = cku_pkg::TAP_IDLE;
          nxt_st.tap_cnt = '0;
        end
      end
      default: begin
        nxt_st.tap     = cku_pkg::TAP_IDLE;
        nxt_st.tap_cnt = '0;
      end
    endcase

    // channel select: lowest pressed button wins, one channel only
    for (int i = cku_pkg::NCH - 1; i >= 0; i--) begin
      if (chan_btn[i]) begin
        any_btn = 1'b1;
        btn_idx = cku_pkg::CHW'(i);
      end
    end
    if (any_btn) begin
      nxt_st.sel     = btn_idx; // see R1, R4
      nxt_st.mode    = cku_pkg::MODE_VOL;
      nxt_st.tap     = cku_pkg::TAP_IDLE;
      nxt_st.tap_cnt = '0;
      ev[cku_pkg::EV_SEL] = 1'b1;
    end else begin
      if (single_tap || double_tap) begin
        if (st_ff.ch[st_ff.sel].mute) begin
          nxt_st.ch[st_ff.sel].mute = 1'b0; // see R15
          ev[cku_pkg::EV_MUTE] = 1'b1;
        end else if (double_tap) begin
          nxt_st.ch[st_ff.sel].mute = 1'b1; // see R12
          nxt_st.mute_white = (st_ff.mode == cku_pkg::MODE_GAIN); // see R13
          ev[cku_pkg::EV_MUTE] = 1'b1;
        end else if (st_ff.mode == cku_pkg::MODE_VOL) begin
          nxt_st.mode = cku_pkg::MODE_GAIN; // see R5
        end else begin
          nxt_st.mode = cku_pkg::MODE_VOL; // see R8
        end
      end
      // rotation edits the selected channel's volume or gain, saturating
      case (st_ff.mode)
        cku_pkg::MODE_GAIN: begin
          if (turn_up && st_ff.ch[st_ff.sel].gain != cku_pkg::LVL_MAX) begin
            nxt_st.ch[st_ff.sel].gain = st_ff.ch[st_ff.sel].gain + 1'b1;
          end else if (turn_dn && st_ff.ch[st_ff.sel].gain != '0) begin
            nxt_st.ch[st_ff.sel].gain = st_ff.ch[st_ff.sel].gain - 1'b1;
          end
        end
        default: begin
          if (turn_up && st_ff.ch[st_ff.sel].vol != cku_pkg::LVL_MAX) begin
            nxt_st.ch[st_ff.sel].vol = st_ff.ch[st_ff.sel].vol + 1'b1;
          end else if (turn_dn && st_ff.ch[st_ff.sel].vol != '0) begin
            nxt_st.ch[st_ff.sel].vol = st_ff.ch[st_ff.sel].vol - 1'b1;
          end
        end
      endcase
      if (wr_set) begin
        nxt_st.ch[st_ff.sel].setting = bus.wdata[cku_pkg::SETW-1:0]; // see R1
      end
    end

    // gain mode idle timer
    if (st_ff.mode != cku_pkg::MODE_GAIN || activity) begin
      nxt_st.inact_cnt = '0; // see R7
    end else if (st_ff.inact_cnt == INACT_LAST) begin
      nxt_st.inact_cnt = '0;
      nxt_st.mode      = cku_pkg::MODE_VOL; // see R8
    end else begin
      nxt_st.inact_cnt = st_ff.inact_cnt + 1'b1;
    end

    // flash phase for the muted ring
    if (st_ff.flash_cnt == FLASH_LAST) begin
      nxt_st.flash_cnt = '0;
      nxt_st.flash_on  = ~st_ff.flash_on;
    end else begin
      nxt_st.flash_cnt = st_ff.flash_cnt + 1'b1;
    end

    // power-up button combination held for the restore time
    if (st_ff.rs_arm) begin
      if (grille_light_button && feedback_elim_button) begin // see R16
        nxt_st.rs_cnt = st_ff.rs_cnt + 1'b1;
        if (st_ff.rs_cnt == RESTORE_LAST) begin
          nxt_st.rs_arm     = 1'b0;
          nxt_st.restore    = 1'b1;
          nxt_st.pair_clear = 1'b1; // see R18
          nxt_st.sel        = cku_pkg::SEL_DEF;
          nxt_st.mode       = cku_pkg::MODE_VOL;
          // a pending tap or idle count must not act on defaults
          nxt_st.tap        = cku_pkg::TAP_IDLE;
          nxt_st.tap_cnt    = '0;
          nxt_st.inact_cnt  = '0;
          nxt_st.mute_white = 1'b0;
          ev[cku_pkg::EV_RST] = 1'b1;
          for (int i = 0; i < cku_pkg::NCH; i++) begin
            nxt_st.ch[i].vol     = cku_pkg::VOL_DEF;
            nxt_st.ch[i].gain    = cku_pkg::LVL_DEF;
            nxt_st.ch[i].mute    = 1'b0;
            nxt_st.ch[i].setting = cku_pkg::SET_DEF; // see R17
          end
        end
      end else begin
        nxt_st.rs_arm = 1'b0;
      end
    end

    // active controls mirror the selected channel's store
    nxt_st.act = nxt_st.ch[nxt_st.sel]; // see R3

    // selection indicators
    for (int i = 0; i < cku_pkg::NCH; i++) begin
      nxt_st.sel_led[i] = (nxt_st.sel == cku_pkg::CHW'(i)); // see R2
    end

    // ring and mode indicators
    case ({nxt_st.act.mute, nxt_st.mode})
      2'b10, 2'b11: begin
        col = nxt_st.mute_white ? cku_pkg::COL_WHITE : cku_pkg::COL_GREEN; // see R13
      end
      2'b01: begin
        col = cku_pkg::COL_WHITE; // see R5
      end
      default: begin
        col = cku_pkg::COL_GREEN;
      end
    endcase
    lvl = (nxt_st.mode == cku_pkg::MODE_GAIN) ? nxt_st.act.gain : nxt_st.act.vol;
    for (int i = 0; i < cku_pkg::NRING; i++) begin
      if (cku_pkg::LVLW'(i) < lvl && !(nxt_st.act.mute && !nxt_st.flash_on)) begin
        nxt_st.ring[i] = col; // see R9, R10
      end else begin
        nxt_st.ring[i] = cku_pkg::COL_OFF;
      end
    end
    if (clip) begin
      nxt_st.ring[cku_pkg::NRING-1] = cku_pkg::COL_RED; // see R11
      ev[cku_pkg::EV_CLIP] = 1'b1;
    end
    case ({nxt_st.act.mute, nxt_st.mode})
      2'b10, 2'b11: begin
        nxt_st.vol_ind = cku_pkg::COL_RED; // see R14
      end
      2'b01: begin
        nxt_st.vol_ind = cku_pkg::COL_OFF; // see R6
      end
      default: begin
        nxt_st.vol_ind = cku_pkg::COL_GREEN;
      end
    endcase
    nxt_st.gain_ind = (nxt_st.mode == cku_pkg::MODE_GAIN); // see R6

    // interrupt status: a new event beats a same-cycle clear
    if (wr_clr) begin
      nxt_st.irq_st = st_ff.irq_st & ~bus.wdata[cku_pkg::NEV-1:0];
    end
    nxt_st.irq_st = nxt_st.irq_st | ev;
    if (wr_en) begin
      nxt_st.irq_en = bus.wdata[cku_pkg::NEV-1:0];
    end
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);

    // read data, valid the cycle after the strobe only
    nxt_st.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        cku_pkg::OFF_STAT: begin
          nxt_st.rdata[cku_pkg::ST_SEL +: cku_pkg::CHW] = st_ff.sel;
          nxt_st.rdata[cku_pkg::ST_MODE]                = st_ff.mode;
          nxt_st.rdata[cku_pkg::ST_MUTE]                = st_ff.act.mute;
        end
        cku_pkg::OFF_SET: begin
          nxt_st.rdata[cku_pkg::SETW-1:0] = st_ff.act.setting;
        end
        cku_pkg::OFF_IRQ_ST: begin
          nxt_st.rdata[cku_pkg::NEV-1:0] = st_ff.irq_st;
        end
        cku_pkg::OFF_IRQ_CLR: begin
          nxt_st.rdata = '0; // write-only, reads as zero
        end
        cku_pkg::OFF_IRQ_EN: begin
          nxt_st.rdata[cku_pkg::NEV-1:0] = st_ff.irq_en;
        end
        // unmapped reads return zero
        default: begin
          nxt_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.sel        <= cku_pkg::SEL_DEF;
      st_ff.mode       <= cku_pkg::MODE_VOL; // see R5
      st_ff.tap        <= cku_pkg::TAP_IDLE;
      st_ff.rs_arm     <= 1'b1; // see R16
      st_ff.sel_led    <= cku_pkg::NCH'(1);
      st_ff.vol_ind    <= cku_pkg::COL_GREEN;
      st_ff.act.vol    <= cku_pkg::VOL_DEF;
      st_ff.act.gain   <= cku_pkg::LVL_DEF;
      st_ff.act.setting <= cku_pkg::SET_DEF;
      // outputs quiet until the first edge after release
      st_ff.ring       <= '0;
      st_ff.gain_ind   <= 1'b0;
      st_ff.restore    <= 1'b0;
      st_ff.pair_clear <= 1'b0;
      st_ff.irq        <= 1'b0;
      st_ff.rdata      <= '0;
      st_ff.irq_st     <= '0;
      st_ff.irq_en     <= '0;
      for (int i = 0; i < cku_pkg::NCH; i++) begin
        st_ff.ch[i].vol     <= cku_pkg::VOL_DEF;
        st_ff.ch[i].gain    <= cku_pkg::LVL_DEF; // see R9
        st_ff.ch[i].setting <= cku_pkg::SET_DEF;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data    = st_ff.rdata;
  assign sel_led    = st_ff.sel_led;
  assign ring       = st_ff.ring;
  assign vol_ind    = st_ff.vol_ind;
  assign gain_ind   = st_ff.gain_ind;
  assign act        = st_ff.act;
  assign restore    = st_ff.restore;
  assign pair_clear = st_ff.pair_clear;
  assign irq        = st_ff.irq;

endmodule // cku_channel_knob_ui_controller

//--- tb/cku_properties.sv
// cku_properties: port checks on the channel knob controller
// assumes one clock, bound to the controller top
`timescale 1ns/1ns
module cku_properties #(
  parameter int INACT_CYC = 40
) (
  input wire logic                           core_clk,
  input wire logic                           rst,
  input wire logic [cku_pkg::NCH-1:0]        chan_btn,
  input wire cku_pkg::cku_knob_t             knob,
  input wire logic                           clip,
  input wire logic [cku_pkg::NCH-1:0]        sel_led,
  input wire logic [cku_pkg::NRING-1:0][1:0] ring,
  input wire logic [1:0]                     vol_ind,
  input wire logic                           gain_ind,
  input wire cku_pkg::cku_chan_t             act,
  input wire logic                           restore,
  input wire logic                           pair_clear
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int idle_ff;
  logic kick;
  assign kick = knob.press | knob.cw | knob.ccw | (|chan_btn) | !gain_ind;
  always_ff @(posedge core_clk) begin
    if (rst || kick) idle_ff <= 0;
    else idle_ff <= idle_ff + 1;
  end
  sequence s_press;
    !knob.press ##1 knob.press;
  endsequence
  sequence s_calm;
    (!knob.press && chan_btn == '0)[*6];
  endsequence
  sequence s_lone;
    (!knob.press && !act.mute && chan_btn == '0)[*8];
  endsequence
  a_sel_onehot: assert property ($onehot(sel_led)) else $error("sel not one-hot");
  a_pair_clear: assert property (restore == pair_clear) else $error("pair clear apart");
  a_restore_once: assert property (restore |=> !restore) else $error("restore long");
  a_restore_dflt: assert property (restore |-> ##[0:2]
    act == {cku_pkg::VOL_DEF, cku_pkg::LVL_DEF, 1'b0, cku_pkg::SET_DEF})
    else $error("no defaults");
  a_gain_lights: assert property (gain_ind && !act.mute |-> vol_ind == cku_pkg::COL_OFF)
    else $error("vol light on");
  a_mute_red: assert property (act.mute && $past(act.mute) |-> vol_ind == cku_pkg::COL_RED)
    else $error("mute not red");
  a_clip_red: assert property (clip[*3] |-> ring[8] == cku_pkg::COL_RED)
    else $error("clip not red");
  a_idle_bound: assert property (idle_ff <= INACT_CYC + 4) else $error("gain stuck");
  a_tap_hold: assert property (s_press ##1 s_calm |-> gain_ind == $past(gain_ind, 5))
    else $error("tap acted early");
  a_tap_flip: assert property (s_press ##0 !act.mute ##1 s_lone |-> ##[0:3] $changed(gain_ind))
    else $error("tap ignored");
endmodule // cku_properties
bind cku_channel_knob_ui_controller cku_properties #(.INACT_CYC(INACT_CYC)) u_props (
  .core_clk, .rst, .chan_btn, .knob, .clip, .sel_led, .ring, .vol_ind, .gain_ind, .act,
  .restore, .pair_clear);

//--- tb/cku_panel_model.sv
// cku_panel_model: buttons, push-rotate knob and clip source
// assumes tasks are called by the bench at a rising edge
`timescale 1ns/1ns
module cku_panel_model (
  input  wire logic               core_clk,
  output logic [cku_pkg::NCH-1:0] chan_btn,
  output cku_pkg::cku_knob_t      knob,
  output logic                    clip,
  output logic                    grille_light_button,
  output logic                    feedback_elim_button
);
  initial begin
    chan_btn = '0;
    knob = '0;
    clip = 1'b0;
    grille_light_button = 1'b1;
    feedback_elim_button = 1'b1;
  end
  task automatic hold(input logic g, input logic f);
    @(posedge core_clk);
    grille_light_button <= g;
    feedback_elim_button <= f;
  endtask
  task automatic sel(input int i);
    @(posedge core_clk);
    chan_btn <= 6'h01 << i;
    @(posedge core_clk);
    chan_btn <= '0;
  endtask
  task automatic press(input int gap);
    @(posedge core_clk);
    knob.press <= 1'b1;
    @(posedge core_clk);
    knob.press <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
  task automatic tap();
    press(1);
  endtask
  // second rise well inside the tap window
  task automatic dtap();
    press(2);
    press(1);
  endtask
  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge core_clk);
      knob.cw <= up;
      knob.ccw <= !up;
      @(posedge core_clk);
      knob.cw <= 1'b0;
      knob.ccw <= 1'b0;
    end
  endtask
  task automatic hot(input int n);
    @(posedge core_clk);
    clip <= 1'b1;
    repeat (n) @(posedge core_clk);
    clip <= 1'b0;
  endtask
endmodule // cku_panel_model

//--- tb/test_channel_knob_ui_controller.sv
// test_channel_knob_ui_controller: self-checking bench
// assumes short counts: inactivity 40, restore 20, tap 8, flash 4
`timescale 1ns/1ns
module test_channel_knob_ui_controller;
  localparam int TAP = 8;
  logic                           core_clk, rst, clip, gain_ind, restore, pair_clear, irq;
  logic                           grille_light_button, feedback_elim_button, rd_q, s_on, s_off;
  cku_pkg::cku_bus_t              bus;
  cku_pkg::cku_knob_t             knob;
  cku_pkg::cku_chan_t             act;
  logic [31:0]                    rd_data, m, v[6], qe[$], qm[$];
  logic [cku_pkg::NCH-1:0]        chan_btn, sel_led;
  logic [cku_pkg::NRING-1:0][1:0] ring;
  logic [1:0]                     vol_ind;
  int                             n_fail, n_tests, cycles, k;
  cku_channel_knob_ui_controller #(.INACT_CYC(40), .RESTORE_CYC(20), .TAP_CYC(TAP), .FLASH_CYC(4))
    u_cku_channel_knob_ui_controller (.core_clk, .rst, .bus, .rd_data, .chan_btn, .knob, .clip,
    .grille_light_button, .feedback_elim_button, .sel_led, .ring, .vol_ind, .gain_ind, .act,
    .restore, .pair_clear, .irq);
  cku_panel_model u_cku_panel_model (.core_clk, .chan_btn, .knob, .clip, .grille_light_button,
    .feedback_elim_button);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    qe.push_back(e & mk);
    qm.push_back(mk);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    bus.rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_q) begin
      m = qm.pop_front();
      ck(rd_data & m, qe.pop_front());
    end
    rd_q <= bus.rd;
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    bus = '0;
    rd_q = 1'b0;
    k = $urandom(53544);
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    ck(32'(sel_led), 32'h1);
    for (k = 0; k < 40 && restore !== 1'b1; k++) @(negedge core_clk);
    ck({30'h0, restore, pair_clear}, 32'h3);
    u_cku_panel_model.hold(1'b0, 1'b0);
    cyc(2);
    ck(32'(act), 32'({cku_pkg::VOL_DEF, cku_pkg::LVL_DEF, 1'b0, cku_pkg::SET_DEF}));
    for (int i = 0; i < 6; i++) begin
      u_cku_panel_model.sel(i);
      v[i] = $urandom & 32'hffff;
      wr(cku_pkg::OFF_SET, v[i]);
    end
    for (int i = 5; i >= 0; i--) begin
      u_cku_panel_model.sel(i);
      cyc(2);
      ck(32'(sel_led), 32'h1 << i);
      rd(cku_pkg::OFF_STAT, i, 32'h7);
      rd(cku_pkg::OFF_SET, v[i], 32'hffff);
    end
    wr(cku_pkg::OFF_IRQ_EN, 32'h1);
    wr(cku_pkg::OFF_IRQ_CLR, 32'hf);
    cyc(2);
    ck({31'h0, irq}, 32'h0);
    rd(cku_pkg::OFF_IRQ_CLR, 0, 32'hffffffff);
    rd(8'h14, 0, 32'hffffffff);
    u_cku_panel_model.sel(2);
    cyc(3);
    ck({31'h0, irq}, 32'h1);
    rd(cku_pkg::OFF_IRQ_ST, 1, 32'h1);
    wr(cku_pkg::OFF_IRQ_EN, 32'h0);
    cyc(2);
    ck({31'h0, irq}, 32'h0);
    wr(cku_pkg::OFF_IRQ_EN, 32'h1);
    wr(cku_pkg::OFF_IRQ_CLR, 32'h1);
    cyc(2);
    ck({31'h0, irq}, 32'h0);
    u_cku_panel_model.tap();
    cyc(TAP + 2);
    ck({29'h0, vol_ind, gain_ind}, 32'h1);
    ck(32'(ring), 32'h00aaa);
    rd(cku_pkg::OFF_STAT, 32'h10, 32'h10);
    u_cku_panel_model.step(1'b1, 4);
    cyc(2);
    ck(32'(ring), 32'h2aaaa);
    repeat (3) begin
      cyc(20);
      u_cku_panel_model.step(1'b0, 1);
    end
    cyc(30);
    ck({31'h0, gain_ind}, 32'h1);
    cyc(14);
    ck({29'h0, vol_ind, gain_ind}, 32'h2);
    u_cku_panel_model.tap();
    cyc(TAP + 2);
    u_cku_panel_model.tap();
    cyc(TAP + 2);
    ck({31'h0, gain_ind}, 32'h0);
    u_cku_panel_model.hot(4);
    @(posedge core_clk);
    ck(32'(ring[8]), 32'(cku_pkg::COL_RED));
    for (int g = 0; g < 2; g++) begin
      u_cku_panel_model.sel(g);
      cyc(2);
      if (g == 1) begin
        u_cku_panel_model.tap();
        cyc(TAP + 2);
      end
      u_cku_panel_model.dtap();
      cyc(2);
      ck({30'h0, vol_ind}, 32'(cku_pkg::COL_RED));
      rd(cku_pkg::OFF_STAT, 32'h20, 32'h20);
      s_on = 1'b0;
      s_off = 1'b0;
      repeat (12) begin
        @(posedge core_clk);
        if (ring[0] === (g == 1 ? cku_pkg::COL_WHITE : cku_pkg::COL_GREEN)) s_on = 1'b1;
        if (ring[0] === cku_pkg::COL_OFF) s_off = 1'b1;
      end
      ck({30'h0, s_on, s_off}, 32'h3);
      u_cku_panel_model.tap();
      cyc(TAP + 2);
      ck({31'h0, act.mute}, 32'h0);
    end
    // second power-up with only one button held: no restore
    rst <= 1'b1;
    u_cku_panel_model.hold(1'b1, 1'b0);
    cyc(2);
    rst <= 1'b0;
    k = 0;
    repeat (30) begin
      @(negedge core_clk);
      if (restore !== 1'b0 || pair_clear !== 1'b0) k++;
    end
    ck(32'(k), 32'h0);
    ck(32'(sel_led), 32'h1);
    rd(cku_pkg::OFF_STAT, 0, 32'h3f);
    cyc(2);
    summarize();
  end
endmodule // test_channel_knob_ui_controller
